//--- hw/sepc_ctrl.sv
// Command execution for the programming side of a three-wire serial EEPROM.
// Assumes all pins are synchronous to CORE_CLK and that serial clock edges
// are at least four core clocks apart.
//
// Functional notes
// (RULE1) Host holds select low after write commands.
// (RULE2) Host holds select low after erase.
// (RULE3) Select fall starts clear-then-store word write.
// (RULE4) Timed cycle needs no serial clock.
// (RULE5) Busy status driven while selected during cycle.
// (RULE6) Word write clears itself first.
// (RULE7) Erase clears only the addressed location.
// (RULE8) Cleared location reads all ones.
// (RULE9) Enable latch clear after reset.
// (RULE10) Host enables before writing or clearing.
// (RULE11) Enable latch holds until disable or reset.
// (RULE12) Cleared latch blocks all writes and clears.
// (RULE13) Reads ignore the enable latch.
// (RULE14) Erase-all clears every location.
// (RULE15) Erase-all leaves every bit at one.
// (RULE16) Write-all stores word everywhere.
// (RULE17) Write-all needs no prior erase-all.
// (RULE18) Output low while busy, high when ready.
// (RULE19) Program enable gates programming, not latch commands.
// (RULE20) Start bit, opcode, address, then data.
// (RULE21) Opcode and leading address bits select command.
// (RULE22) Refused command starts nothing, output stays off.
// (RULE23) Cycle length is a parameter; ready afterwards.
`timescale 1ns/1ps
`include "sepc_cfg.svh"

module sepc_ctrl #(
   parameter int EW_CYCLES = `SEPC_EW_CYCLES
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // Serial pins
   input wire logic CHIP_SELECT,
   input wire logic SERIAL_CLOCK,
   input wire logic SERIAL_IN,
   output logic SERIAL_OUT,
   output logic SERIAL_OUT_OE,
   // Straps
   input wire logic PROGRAM_ENABLE_PIN,
   input wire logic WORD_WIDTH_SELECT,
   // Status
   output logic BUSY,
   output logic WRITE_ENABLED
);
   import sepc_pkg::*;

   localparam int TW = $clog2(EW_CYCLES + 1);
   localparam logic [TW-1:0] TIMER_LAST = TW'(EW_CYCLES - 1);

   // ========================================================================
   // State
   typedef struct packed {
      sepc_state_t st;
      logic sclk_q;
      logic cs_q;
      logic [4:0] cnt;
      logic [28:0] sh;
      sepc_op_t op;
      logic wen;
      logic busy;
      logic poll;
      sepc_op_t run_op;
      logic [10:0] addr;
      logic [15:0] data;
      logic phase;
      logic [9:0] sweep;
      logic sweep_done;
      logic [TW-1:0] timer;
      logic [1:0] rd_load;
      logic [15:0] dout_sh;
      logic [4:0] dout_cnt;
      logic rd_bit;
      logic do_v;
      logic do_oe;
   } sepc_ctl_t;

   sepc_ctl_t s_r;
   sepc_ctl_t s_nxt;
   sepc_mem_req_t mreq;
   logic [15:0] rdata;
   logic byte_mode;
   logic sclk_rise;
   logic cs_fall;
   logic [4:0] abits;
   logic [4:0] dbits;
   logic [4:0] cnt_n;
   logic [28:0] sh_n;
   logic [1:0] opc;
   logic [1:0] sub;
   logic [10:0] adr_n;
   logic [15:0] wd_n;
   logic [1:0] lane;
   logic [15:0] rd_word;

   assign byte_mode = !WORD_WIDTH_SELECT;
   assign sclk_rise = SERIAL_CLOCK && !s_r.sclk_q;
   assign cs_fall = !CHIP_SELECT && s_r.cs_q;
   assign abits = byte_mode ? 5'(`SEPC_BADDR_BITS) : 5'(`SEPC_WADDR_BITS);
   assign dbits = byte_mode ? 5'(`SEPC_BYTE_BITS) : 5'(`SEPC_WORD_BITS);
   assign lane = byte_mode ? (s_r.addr[0] ? 2'h2 : 2'h1) : 2'h3;

   // ========================================================================
   // Field extraction from the incoming bit stream
   assign sh_n = {s_r.sh[27:0], SERIAL_IN};
   assign cnt_n = s_r.cnt + 5'h01;
   assign opc = byte_mode ? sh_n[12:11] : sh_n[11:10];
   assign adr_n = byte_mode ? sh_n[10:0] : {1'b0, sh_n[9:0]};
   assign sub = byte_mode ? sh_n[10:9] : sh_n[9:8];
   assign wd_n = byte_mode ? {sh_n[7:0], sh_n[7:0]} : sh_n[15:0];
   assign rd_word = byte_mode ? {(s_r.addr[0] ? rdata[15:8] : rdata[7:0]), 8'h00} : rdata;

   // ========================================================================
   // Next state
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.sclk_q = SERIAL_CLOCK;
      s_nxt.cs_q = CHIP_SELECT;
      mreq = '0;
      mreq.addr = byte_mode ? s_r.addr[10:1] : s_r.addr[9:0];

      // (RULE4) Self-timed engine
      // Runs from the core clock alone once started.
      if (s_r.busy)
      begin
         if (s_r.timer != TIMER_LAST)
            s_nxt.timer = s_r.timer + TW'(1);
         if (!s_r.sweep_done)
         begin
            mreq.we = 1'b1;
            unique case (s_r.run_op)
               OP_WRITE:
               begin
                  // (RULE3) (RULE6) Clear then store
                  mreq.bmask = lane;
                  mreq.wdata = s_r.phase ? s_r.data : `SEPC_CLEAR_WORD;
                  s_nxt.phase = 1'b1;
                  s_nxt.sweep_done = s_r.phase;
               end
               OP_ERASE:
               begin
                  // (RULE7) (RULE8) Single location to ones
                  mreq.bmask = lane;
                  mreq.wdata = `SEPC_CLEAR_WORD;
                  s_nxt.sweep_done = 1'b1;
               end
               OP_ERASE_ALL, OP_WRITE_ALL:
               begin
                  // (RULE14) (RULE15) (RULE16) (RULE17) Whole array sweep
                  // Every word is overwritten, so old contents never matter.
                  mreq.addr = s_r.sweep;
                  mreq.bmask = 2'h3;
                  mreq.wdata = (s_r.run_op == OP_WRITE_ALL) ? s_r.data : `SEPC_CLEAR_WORD;
                  s_nxt.sweep = s_r.sweep + 10'h001;
                  s_nxt.sweep_done = (s_r.sweep == `SEPC_LAST_WORD);
               end
               default:
               begin
                  mreq.we = 1'b0;
                  s_nxt.sweep_done = 1'b1;
               end
            endcase
         end
         // (RULE23) Ready after the parameter length
         if (s_r.timer == TIMER_LAST && s_r.sweep_done)
            s_nxt.busy = 1'b0;
      end

      // Read word fetch waits for the array address and its output register.
      if (s_r.rd_load != 2'h0)
      begin
         s_nxt.rd_load = s_r.rd_load - 2'h1;
         if (s_r.rd_load == 2'h1)
            s_nxt.dout_sh = rd_word;
      end

      if (!CHIP_SELECT)
      begin
         s_nxt.st = ST_IDLE;
         s_nxt.cnt = 5'h00;
         s_nxt.op = OP_NONE;
         s_nxt.rd_load = 2'h0;
         if (cs_fall && s_r.st == ST_HOLD)
         begin
            unique case (s_r.op)
               // (RULE11) (RULE19) Latch set or cleared, pin ignored
               OP_ENABLE:
                  s_nxt.wen = 1'b1;
               OP_DISABLE:
                  s_nxt.wen = 1'b0;
               OP_NONE:
                  s_nxt.wen = s_r.wen;
               default:
               begin
                  // (RULE12) (RULE19) (RULE22) Gate by latch and pin
                  if (s_r.wen && PROGRAM_ENABLE_PIN)
                  begin
                     s_nxt.busy = 1'b1;
                     s_nxt.poll = 1'b1;
                     s_nxt.run_op = s_r.op;
                     s_nxt.timer = '0;
                     s_nxt.phase = 1'b0;
                     s_nxt.sweep = 10'h000;
                     s_nxt.sweep_done = 1'b0;
                  end
               end
            endcase
         end
      end
      else if (sclk_rise)
      begin
         unique case (s_r.st)
            ST_IDLE:
            begin
               // (RULE20) Start bit; a one also ends status polling
               if (SERIAL_IN)
               begin
                  s_nxt.poll = 1'b0;
                  if (!s_r.busy)
                  begin
                     s_nxt.st = ST_SHIFT;
                     s_nxt.cnt = 5'h00;
                     s_nxt.sh = '0;
                  end
               end
            end
            ST_SHIFT:
            begin
               s_nxt.sh = sh_n;
               s_nxt.cnt = cnt_n;
               if (cnt_n == abits + 5'h02)
               begin
                  s_nxt.addr = adr_n;
                  // (RULE21) Command decode
                  unique case (opc)
                     `SEPC_OPC_READ:
                     begin
                        // (RULE13) Read without latch check
                        s_nxt.st = ST_READ;
                        s_nxt.rd_load = `SEPC_READ_FETCH;
                        s_nxt.rd_bit = 1'b0;
                        s_nxt.dout_cnt = 5'h00;
                     end
                     `SEPC_OPC_ERASE:
                     begin
                        s_nxt.op = OP_ERASE;
                        s_nxt.st = ST_HOLD;
                     end
                     `SEPC_OPC_WRITE:
                        s_nxt.op = OP_WRITE;
                     `SEPC_OPC_SPECIAL:
                     begin
                        unique case (sub)
                           `SEPC_SUB_ENABLE:
                           begin
                              s_nxt.op = OP_ENABLE;
                              s_nxt.st = ST_HOLD;
                           end
                           `SEPC_SUB_DISABLE:
                           begin
                              s_nxt.op = OP_DISABLE;
                              s_nxt.st = ST_HOLD;
                           end
                           `SEPC_SUB_ERASE_ALL:
                           begin
                              s_nxt.op = OP_ERASE_ALL;
                              s_nxt.st = ST_HOLD;
                           end
                           `SEPC_SUB_WRITE_ALL:
                              s_nxt.op = OP_WRITE_ALL;
                        endcase
                     end
                  endcase
               end
               else if (cnt_n == abits + dbits + 5'h02)
               begin
                  // (RULE20) Data field closes write-type frames
                  s_nxt.data = wd_n;
                  s_nxt.st = ST_HOLD;
               end
            end
            ST_HOLD:
               s_nxt.st = ST_HOLD;
            ST_READ:
            begin
               // Dummy zero first, then data MSB first, then the next address.
               s_nxt.rd_bit = s_r.dout_sh[15];
               s_nxt.dout_sh = {s_r.dout_sh[14:0], 1'b0};
               s_nxt.dout_cnt = s_r.dout_cnt + 5'h01;
               if (s_r.dout_cnt == dbits - 5'h01)
               begin
                  s_nxt.dout_cnt = 5'h00;
                  s_nxt.rd_load = `SEPC_READ_FETCH;
                  s_nxt.addr = byte_mode ? s_r.addr + 11'h001 : {1'b0, s_r.addr[9:0] + 10'h001};
               end
            end
         endcase
      end

      // (RULE5) (RULE18) Status on the output while selected
      s_nxt.do_oe = CHIP_SELECT && (s_nxt.poll || s_nxt.st == ST_READ);
      s_nxt.do_v = s_nxt.poll ? !s_nxt.busy : s_nxt.rd_bit;
   end

   // ========================================================================
   // Registers
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      // (RULE9) Latch disabled at reset
      if (!RST_N)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // ========================================================================
   // Array
   sepc_array #(
      .AW(`SEPC_WADDR_BITS),
      .DW(`SEPC_WORD_BITS)
   ) u_array (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .req(mreq),
      .rdata(rdata)
   );

   assign SERIAL_OUT = s_r.do_v;
   assign SERIAL_OUT_OE = s_r.do_oe;
   assign BUSY = s_r.busy;
   assign WRITE_ENABLED = s_r.wen;

endmodule

//--- hw/sepc_cfg.svh
// Constants of the serial EEPROM program control block.
// Assumes nothing of its surroundings; included by the package and the controller.
`ifndef SEPC_CFG_SVH
`define SEPC_CFG_SVH

// ==========================================================================
// Geometry
`define SEPC_WORD_BITS 16
`define SEPC_BYTE_BITS 8
`define SEPC_WADDR_BITS 10
`define SEPC_BADDR_BITS 11
`define SEPC_OPC_BITS 2

// ==========================================================================
// Instruction encodings
`define SEPC_OPC_READ 2'h2
`define SEPC_OPC_ERASE 2'h3
`define SEPC_OPC_WRITE 2'h1
`define SEPC_OPC_SPECIAL 2'h0
`define SEPC_SUB_ENABLE 2'h3
`define SEPC_SUB_DISABLE 2'h0
`define SEPC_SUB_ERASE_ALL 2'h2
`define SEPC_SUB_WRITE_ALL 2'h1

// ==========================================================================
// Timing
`define SEPC_CLK_PERIOD_NS 10
`define SEPC_EW_TIME_NS 5000000
`define SEPC_EW_CYCLES (`SEPC_EW_TIME_NS / `SEPC_CLK_PERIOD_NS)
`define SEPC_READ_FETCH 2'h2

// ==========================================================================
// Reset and fill values
`define SEPC_CLEAR_WORD 16'hFFFF
`define SEPC_LAST_WORD 10'h3FF

`endif

//--- hw/sepc_pkg.sv
// Types shared by the serial EEPROM program control block.
// Assumes the constants header sits beside it.
`include "sepc_cfg.svh"

package sepc_pkg;

   // =======================================================================
   // Controller states and decoded commands
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_HOLD, ST_READ} sepc_state_t;

   typedef enum logic [2:0] {
      OP_NONE, OP_WRITE, OP_ERASE, OP_ERASE_ALL, OP_WRITE_ALL, OP_ENABLE, OP_DISABLE
   } sepc_op_t;

   // =======================================================================
   // Array access request
   typedef struct packed {
      logic we;
      logic [1:0] bmask;
      logic [`SEPC_WADDR_BITS-1:0] addr;
      logic [`SEPC_WORD_BITS-1:0] wdata;
   } sepc_mem_req_t;

endpackage

//--- hw/sepc_array.sv
// Nonvolatile word array model with byte-lane writes and registered read data.
// Assumes one request per clock from the controller; reads see the stored word.
`timescale 1ns/1ps
`include "sepc_cfg.svh"

module sepc_array #(
   parameter int AW = `SEPC_WADDR_BITS,
   parameter int DW = `SEPC_WORD_BITS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Access
   input sepc_pkg::sepc_mem_req_t req,
   output logic [DW-1:0] rdata
);
   import sepc_pkg::*;

   typedef struct packed {
      logic [DW-1:0] rdata;
   } sepc_arr_t;

   sepc_arr_t s_r;
   sepc_arr_t s_nxt;
   logic [DW-1:0] rd_lanes;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rdata = rd_lanes;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ========================================================================
   // Storage has no reset, as a real cell array keeps its contents.
   // Each byte lane owns its storage, so no two processes write one array.
   for (genvar b = 0; b < DW / 8; b++)
   begin : g_lane
      logic [7:0] mem [0:(1 << AW)-1];
      assign rd_lanes[b*8 +: 8] = mem[req.addr];
      always_ff @(posedge clk)
      begin
         if (req.we && req.bmask[b])
         begin
            mem[req.addr] <= req.wdata[b*8 +: 8];
         end
      end
   end

   assign rdata = s_r.rdata;

endmodule

//--- sim/sepc_host.sv
// Host model that drives select, serial clock and data into the controller.
// Assumes the bench resolves the data output wire and calls these tasks.
`timescale 1ns/1ps

module sepc_host (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic cs,
   output logic sclk,
   output logic sdin,
   input wire logic so_w
);
   initial
   begin
      cs = 1'h0;
      sclk = 1'h0;
      sdin = 1'h0;
   end

   // One serial clock pulse; rises stay four core clocks apart.
   task automatic pulse(input logic b);
      sdin <= b;
      repeat (2) @(posedge clk);
      sclk <= 1'h1;
      repeat (2) @(posedge clk);
      sclk <= 1'h0;
   endtask

   task automatic sel(input logic b);
      cs <= b;
      repeat (3) @(posedge clk);
   endtask

   task automatic frame(input logic [28:0] f, input int n);
      cs <= 1'h1;
      for (int i = n - 1; i >= 0; i--)
         pulse(f[i]);
      @(posedge clk);
      cs <= 1'h0;
      sdin <= ~f[0];
      repeat (3) @(posedge clk);
   endtask

   // Returns the leading dummy bit above the sixteen data bits.
   task automatic read_word(input logic [9:0] a, output logic [16:0] w);
      logic [12:0] f;
      f = {3'h6, a};
      cs <= 1'h1;
      for (int i = 12; i >= 0; i--)
         pulse(f[i]);
      for (int i = 16; i >= 0; i--)
      begin
         if (i < 16)
            pulse(1'h0);
         repeat (2) @(posedge clk);
         w[i] = so_w;
      end
      sel(1'h0);
   endtask
endmodule

//--- sim/sepc_ctrl_chk.sv
// Concurrent checks on the ports of the program control block.
// Assumes one clock domain; bound to every instance of the controller.
`timescale 1ns/1ps

module sepc_ctrl_chk #(
   parameter int EW_CYCLES = 1100
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // Serial pins
   input wire logic CHIP_SELECT,
   input wire logic SERIAL_OUT,
   input wire logic SERIAL_OUT_OE,
   // Straps and status
   input wire logic PROGRAM_ENABLE_PIN,
   input wire logic BUSY,
   input wire logic WRITE_ENABLED
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);

   // ======================================================================
   // Busy length counter
   int unsigned busy_cnt_r;
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
         busy_cnt_r <= 0;
      else if (BUSY)
         busy_cnt_r <= busy_cnt_r + 1;
      else
         busy_cnt_r <= 0;
   end

   // ======================================================================
   // Assertions
   a_busy_start: assert property (
      $rose(BUSY) |-> !$past(CHIP_SELECT) && $past(CHIP_SELECT, 2))
      else $error("busy rose without a select fall");
   a_busy_len: assert property (
      $fell(BUSY) |-> busy_cnt_r == EW_CYCLES)
      else $error("busy length differs from cycle parameter");
   a_busy_gate: assert property (
      $rose(BUSY) |-> $past(WRITE_ENABLED) && $past(PROGRAM_ENABLE_PIN))
      else $error("cycle started while programming locked");
   a_latch_change: assert property (
      $changed(WRITE_ENABLED) |-> !$past(CHIP_SELECT) && $past(CHIP_SELECT, 2))
      else $error("latch changed without a command");
   a_latch_reset: assert property (
      !$past(RST_N) |-> !WRITE_ENABLED && !BUSY)
      else $error("latch or busy set after reset");
   a_oe_desel: assert property (
      !CHIP_SELECT [*3] |-> !SERIAL_OUT_OE)
      else $error("output driven while deselected");
   a_status_busy: assert property (
      SERIAL_OUT_OE && BUSY && $past(BUSY) |-> !SERIAL_OUT)
      else $error("status not low while busy");
   a_status_ready: assert property (
      $fell(BUSY) ##1 SERIAL_OUT_OE |-> SERIAL_OUT)
      else $error("status not high when ready");

   c_cycle: cover property ($rose(BUSY));
   c_ready: cover property ($fell(BUSY) ##1 SERIAL_OUT_OE);
   c_enable: cover property ($rose(WRITE_ENABLED));
endmodule

bind sepc_ctrl sepc_ctrl_chk #(.EW_CYCLES(EW_CYCLES)) u_sepc_ctrl_chk (
   .CORE_CLK(CORE_CLK),
   .RST_N(RST_N),
   .CHIP_SELECT(CHIP_SELECT),
   .SERIAL_OUT(SERIAL_OUT),
   .SERIAL_OUT_OE(SERIAL_OUT_OE),
   .PROGRAM_ENABLE_PIN(PROGRAM_ENABLE_PIN),
   .BUSY(BUSY),
   .WRITE_ENABLED(WRITE_ENABLED)
);

//--- sim/tb.sv
// Self-checking bench for the program control block in word and byte mode.
// Assumes the controller, its array, the host model and checker are compiled.
`timescale 1ns/1ps

module tb;
   localparam int EW = 1100;
   logic clk;
   logic rst_n;
   logic prog_en;
   logic word_mode;
   logic so;
   logic oe;
   logic busy;
   logic wen;
   wire cs;
   wire sclk;
   wire sdin;
   wire do_w;
   int err_count = 0;
   int compares = 0;

   assign do_w = oe ? so : 1'hz;

   sepc_host u_sepc_host (.clk(clk), .cs(cs), .sclk(sclk), .sdin(sdin), .so_w(do_w));

   sepc_ctrl #(.EW_CYCLES(EW)) u_sepc_ctrl (
      .CORE_CLK(clk), .RST_N(rst_n), .CHIP_SELECT(cs), .SERIAL_CLOCK(sclk),
      .SERIAL_IN(sdin), .SERIAL_OUT(so), .SERIAL_OUT_OE(oe), .PROGRAM_ENABLE_PIN(prog_en),
      .WORD_WIDTH_SELECT(word_mode), .BUSY(busy), .WRITE_ENABLED(wen));

   always #5 clk = ~clk;

   // ======================================================================
   // Compare and report
   task automatic check_bit(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic check_word(input string what, input logic [16:0] exp, input logic [16:0] got);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop;
      if (err_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ======================================================================
   // Command and read helpers
   task automatic run(input logic [28:0] f, input int n, input logic go);
      u_sepc_host.frame(f, n);
      check_bit("busy", go, busy);
      if (go)
      begin
         u_sepc_host.sel(1'h1);
         check_bit("status busy", 1'h0, do_w);
         for (int i = 0; i < 2000 && busy; i++)
            @(posedge clk);
         repeat (2) @(posedge clk);
         check_bit("status ready", 1'h1, do_w);
         u_sepc_host.pulse(1'h1);
         repeat (3) @(posedge clk);
         check_bit("status off", 1'h0, oe);
         u_sepc_host.sel(1'h0);
      end
      else
      begin
         u_sepc_host.sel(1'h1);
         check_bit("output off", 1'h0, oe);
         u_sepc_host.sel(1'h0);
      end
   endtask

   task automatic rd(input logic [9:0] a, input logic [15:0] exp);
      logic [16:0] w;
      u_sepc_host.read_word(a, w);
      check_word("read word", {1'h0, exp}, w);
   endtask

   // ======================================================================
   // Scenarios
   task automatic t_locked;
      check_bit("latch after reset", 1'h0, wen);
      run({3'h5, 10'h005, 16'h1234}, 29, 1'h0);
   endtask

   task automatic t_enable;
      prog_en <= 1'h0;
      run({16'h0000, 3'h4, 10'h300}, 13, 1'h0);
      check_bit("latch set", 1'h1, wen);
      run({3'h5, 10'h005, 16'h1234}, 29, 1'h0);
      prog_en <= 1'h1;
   endtask

   task automatic t_write;
      run({3'h5, 10'h005, 16'hA5C3}, 29, 1'h1);
      rd(10'h005, 16'hA5C3);
      run({3'h5, 10'h005, 16'h5A3C}, 29, 1'h1);
      rd(10'h005, 16'h5A3C);
      run({3'h5, 10'h006, 16'h0F0F}, 29, 1'h1);
   endtask

   task automatic t_erase;
      run({16'h0000, 3'h7, 10'h005}, 13, 1'h1);
      rd(10'h005, 16'hFFFF);
      rd(10'h006, 16'h0F0F);
   endtask

   // Byte write to the high byte of word 5 keeps the low byte cleared.
   task automatic t_byte;
      word_mode <= 1'h0;
      run({3'h5, 11'h00B, 8'h5A}, 22, 1'h1);
      word_mode <= 1'h1;
      rd(10'h005, 16'h5AFF);
   endtask

   task automatic t_all;
      run({3'h4, 10'h100, 16'hC33C}, 29, 1'h1);
      rd(10'h000, 16'hC33C);
      rd(10'h3FF, 16'hC33C);
      run({16'h0000, 3'h4, 10'h200}, 13, 1'h1);
      rd(10'h006, 16'hFFFF);
      rd(10'h3FF, 16'hFFFF);
   endtask

   task automatic t_disable;
      run({16'h0000, 3'h4, 10'h000}, 13, 1'h0);
      check_bit("latch cleared", 1'h0, wen);
      run({16'h0000, 3'h7, 10'h001}, 13, 1'h0);
      run({16'h0000, 3'h4, 10'h200}, 13, 1'h0);
      run({3'h4, 10'h100, 16'h0000}, 29, 1'h0);
      rd(10'h001, 16'hFFFF);
   endtask

   // ======================================================================
   // Main sequence and watchdog
   initial
   begin
      clk = 1'h0;
      rst_n = 1'h0;
      prog_en = 1'h1;
      word_mode = 1'h1;
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      repeat (2) @(posedge clk);
      t_locked();
      t_enable();
      t_write();
      t_erase();
      t_byte();
      t_all();
      t_disable();
      report_and_stop();
   end

   initial
   begin
      repeat (30000) @(posedge clk);
      err_count++;
      report_and_stop();
   end
endmodule
